// ==== verif/access_fault_event_irq_enable_tb.sv ====
// Self-checking bench for the access fault block
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin error_cnt++; \
	$display("MISMATCH %s exp %h got %h", n, e, a); end end
module access_fault_event_irq_enable_tb;
	import fault_irq_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [ADDR_W-1:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [2:0] det = 0;
	logic [15:0] publish_channel, pub;
	logic pready, pslverr, irq, err, ok;
	int error_cnt = 0, checked = 0;
	logic [31:0] cfg [4] = '{32'h80000000, 32'h8000000F, 32'h80000010, 32'hF};
	logic [15:0] exp_ch [4] = '{16'h0001, 16'h8000, 16'h0000, 16'h0000};
	always #50 pclk = ~pclk;
	access_fault_event_irq_enable #(.NUM_CHANNELS(16)) i_access_fault_event_irq_enable (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .ram_violation_detect(det[0]),
		.flash_violation_detect(det[1]), .periph_violation_detect(det[2]),
		.publish_channel, .irq);
	// Print the counts and the verdict
	task automatic stop_test();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	// One APB transfer, then one idle cycle
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		int n;
		ok = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// Answer is taken at the rising edge where pready is high
		for (n = 0; n < 20 && ok !== 1'b1; n++) begin
			@(posedge pclk);
			{ok, err, rd} = {pready, pslverr, prdata};
		end
		if (ok !== 1'b1) begin
			error_cnt++;
			stop_test();
		end
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : apb
	// One-cycle detect pulse, catching the publish output
	task automatic pulse(input logic [2:0] v);
		det <= v;
		@(posedge pclk);
		det <= 0;
		@(negedge pclk);
		pub = publish_channel;
		@(posedge pclk);
	endtask : pulse
	task automatic irq_is(input logic e);
		@(negedge pclk);
		`CHK("irq", e, irq)
		@(posedge pclk);
	endtask : irq_is
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, OFF_FAULT_IRQ_ENABLE_CLEAR, 0);
		`CHK("enable reset", 32'h0, rd)
		apb(0, 12'h004, 0);
		`CHK("unmapped err", 1'b1, err)
		apb(1, OFF_FAULT_IRQ_ENABLE, 32'h5);
		apb(0, OFF_FAULT_IRQ_ENABLE, 0);
		`CHK("fault_irq_enable", 32'h5, rd)
		apb(1, OFF_FAULT_IRQ_ENABLE_SET, 32'h2);
		apb(1, OFF_FAULT_IRQ_ENABLE_SET, 32'h0);
		apb(0, OFF_FAULT_IRQ_ENABLE_SET, 0);
		`CHK("fault_irq_enable_set", 32'h7, rd)
		apb(1, OFF_FAULT_IRQ_ENABLE_CLEAR, 32'h5);
		apb(1, OFF_FAULT_IRQ_ENABLE_CLEAR, 32'h0);
		apb(0, OFF_FAULT_IRQ_ENABLE_CLEAR, 0);
		`CHK("fault_irq_enable_clear", 32'h2, rd)
		// Each event: masked, then enabled, then cleared
		for (int i = 0; i < 3; i++) begin
			apb(1, OFF_FAULT_IRQ_ENABLE, 32'h0);
			pulse(3'(1 << i));
			irq_is(1'b0);
			apb(1, OFF_FAULT_IRQ_ENABLE_SET, 32'(1 << i));
			irq_is(1'b1);
			apb(0, OFF_EVT_RAM + 12'(4 * i), 0);
			`CHK("event", 32'h1, rd)
			apb(1, OFF_EVT_RAM + 12'(4 * i), 0);
			irq_is(1'b0);
		end
		// Channel boundaries and publish off
		for (int i = 0; i < 4; i++) begin
			apb(1, OFF_PUBLISH, cfg[i]);
			apb(0, OFF_PUBLISH, 0);
			`CHK("publish cfg", cfg[i], rd)
			pulse(3'h4);
			`CHK("channel", exp_ch[i], pub)
		end
		stop_test();
	end
endmodule : access_fault_event_irq_enable_tb

// ==== verif/fault_irq_props.sv ====
// Assertions on the access fault block ports
`timescale 1ns/1ps
module fault_irq_chk #(
	parameter int NUM_CHANNELS = 16
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Access
	input wire logic pwrite, // Direction
	input wire logic [fault_irq_pkg::ADDR_W-1:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic ram_violation_detect, // RAM fault
	input wire logic flash_violation_detect, // Flash fault
	input wire logic periph_violation_detect, // Periph fault
	input wire logic [NUM_CHANNELS-1:0] publish_channel, // Channels
	input wire logic irq // Interrupt
);
	import fault_irq_pkg::*;
	logic [2:0] en_reg; // Expected enables
	logic [16:0] pc_reg; // Expected publish enable and channel
	wire logic wr = psel && penable && pwrite;
	wire logic rd = psel && penable && !pwrite;
	// Follow what software writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_reg <= 3'h0;
			pc_reg <= 17'h0;
		end else if (wr) begin
			case (paddr)
			OFF_FAULT_IRQ_ENABLE: en_reg <= pwdata[2:0];
			OFF_FAULT_IRQ_ENABLE_SET: en_reg <= en_reg | pwdata[2:0];
			OFF_FAULT_IRQ_ENABLE_CLEAR: en_reg <= en_reg & ~pwdata[2:0];
			OFF_PUBLISH: pc_reg <= {pwdata[31], pwdata[15:0]};
			default: ;
			endcase
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	en_read_a: assert property (rd && paddr == OFF_FAULT_IRQ_ENABLE
		|-> prdata == {29'h0, en_reg}) else $error("enable readback");
	set_read_a: assert property (rd && paddr == OFF_FAULT_IRQ_ENABLE_SET
		|-> prdata[2:0] == en_reg) else $error("set readback");
	clr_read_a: assert property (rd && paddr == OFF_FAULT_IRQ_ENABLE_CLEAR
		|-> prdata[2:0] == en_reg) else $error("clear readback");
	ram_irq_a: assert property (ram_violation_detect ##1 en_reg[0]
		|=> irq) else $error("ram irq missing");
	flash_irq_a: assert property (flash_violation_detect ##1 en_reg[1]
		|=> irq) else $error("flash irq missing");
	per_irq_a: assert property (periph_violation_detect ##1 en_reg[2]
		|=> irq) else $error("periph irq missing");
	irq_off_a: assert property (en_reg == 3'h0 |=> !irq)
		else $error("irq while disabled");
	pub_on_a: assert property (periph_violation_detect && pc_reg[16]
		&& pc_reg[15:0] < NUM_CHANNELS
		|=> publish_channel == NUM_CHANNELS'(1) << $past(pc_reg[15:0]))
		else $error("publish on wrong channel");
	pub_off_a: assert property (!periph_violation_detect || !pc_reg[16]
		|=> publish_channel == '0) else $error("publish when off");
	cover property ($rose(irq));
	cover property (publish_channel != '0);
	cover property (pslverr);
endmodule : fault_irq_chk
bind access_fault_event_irq_enable fault_irq_chk #(
	.NUM_CHANNELS(NUM_CHANNELS)) i_fault_irq_chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.ram_violation_detect, .flash_violation_detect,
	.periph_violation_detect, .publish_channel, .irq);

// ==== verilog/access_fault_event_irq_enable.sv ====
// Access fault events, publish and interrupt enable with an APB slave
`timescale 1ns/1ps
module access_fault_event_irq_enable #(
	parameter int NUM_CHANNELS = 16
) (
	input wire logic pclk, // Clock, 10 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction, 1 = write
	input wire logic [fault_irq_pkg::ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error for unmapped address
	input wire logic ram_violation_detect, // RAM fault pulse
	input wire logic flash_violation_detect, // Flash fault pulse
	input wire logic periph_violation_detect, // Peripheral fault pulse
	output logic [NUM_CHANNELS-1:0] publish_channel, // Channel pulses
	output logic irq // Level interrupt
);
	import fault_irq_pkg::*;

	logic [NUM_EVENTS-1:0] detect;
	logic [NUM_EVENTS-1:0] events;
	logic [NUM_EVENTS-1:0] evt_wr;
	reg_write_t wr;
	logic mapped;
	publish_cfg_t pub_reg;
	publish_cfg_t pub_next;
	logic [NUM_EVENTS-1:0] fault_irq_enable_reg;
	logic [NUM_EVENTS-1:0] fault_irq_enable_next;
	logic [31:0] rdata_next;
	logic [31:0] rdata_reg;
	logic err_next;
	logic err_reg;
	logic irq_next;
	logic irq_reg;

	assign detect = {periph_violation_detect, flash_violation_detect,
		ram_violation_detect};

	// Single-cycle access phase: always ready
	assign pready = 1'b1;

	// Address decode
	always_comb begin
		case (paddr)
			OFF_EVT_RAM, OFF_EVT_FLASH, OFF_EVT_PERIPH, OFF_PUBLISH,
			OFF_FAULT_IRQ_ENABLE, OFF_FAULT_IRQ_ENABLE_SET, OFF_FAULT_IRQ_ENABLE_CLEAR: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Write strobe taken in the access phase
	always_comb begin
		wr.wr = psel && penable && pwrite && mapped;
		wr.addr = paddr;
		wr.data = pwdata;
		evt_wr[POS_RAM] = wr.wr && (wr.addr == OFF_EVT_RAM);
		evt_wr[POS_FLASH] = wr.wr && (wr.addr == OFF_EVT_FLASH);
		evt_wr[POS_PERIPH] = wr.wr && (wr.addr == OFF_EVT_PERIPH);
	end

	// Sticky event registers, one per event
	genvar g;
	generate
		for (g = 0; g < NUM_EVENTS; g++) begin : gen_evt
			fault_event_flag u_flag (
				.pclk(pclk),
				.presetn(presetn),
				.detect(detect[g]),
				.sw_write(evt_wr[g]),
				.sw_value(pwdata[0]),
				.flag(events[g])
			);
		end
	endgenerate

	// Publish path for the peripheral fault
	fault_publish #(
		.NUM_CHANNELS(NUM_CHANNELS)
	) u_publish (
		.pclk(pclk),
		.presetn(presetn),
		.cfg(pub_reg),
		.event_pulse(periph_violation_detect),
		.channel_pulse(publish_channel)
	);

	// Configuration and enable next values
	always_comb begin
		pub_next = pub_reg;
		fault_irq_enable_next = fault_irq_enable_reg;
		if (wr.wr) begin
			case (wr.addr)
				OFF_PUBLISH: begin
					pub_next.channel = wr.data[POS_PUBLISH_CHANNEL_INDEX +: PUBLISH_CHANNEL_INDEX_W];
					pub_next.enable = wr.data[POS_PUB_EN];
				end
				OFF_FAULT_IRQ_ENABLE: begin
					fault_irq_enable_next[POS_RAM] = wr.data[POS_RAM];
					fault_irq_enable_next[POS_FLASH] = wr.data[POS_FLASH];
					fault_irq_enable_next[POS_PERIPH] = wr.data[POS_PERIPH];
				end
				OFF_FAULT_IRQ_ENABLE_SET: begin
					// Zero bits leave enables untouched
					fault_irq_enable_next = fault_irq_enable_reg | wr.data[NUM_EVENTS-1:0];
				end
				OFF_FAULT_IRQ_ENABLE_CLEAR: begin
					fault_irq_enable_next = fault_irq_enable_reg & ~wr.data[NUM_EVENTS-1:0];
				end
				default: begin
					fault_irq_enable_next = fault_irq_enable_reg;
				end
			endcase
		end
	end

	// Read data, error and interrupt next values
	always_comb begin
		rdata_next = 32'h0000_0000;
		err_next = 1'b0;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				OFF_EVT_RAM: rdata_next[0] = events[POS_RAM];
				OFF_EVT_FLASH: rdata_next[0] = events[POS_FLASH];
				OFF_EVT_PERIPH: rdata_next[0] = events[POS_PERIPH];
				OFF_PUBLISH: begin
					rdata_next[POS_PUBLISH_CHANNEL_INDEX +: PUBLISH_CHANNEL_INDEX_W] = pub_reg.channel;
					rdata_next[POS_PUB_EN] = pub_reg.enable;
				end
				OFF_FAULT_IRQ_ENABLE, OFF_FAULT_IRQ_ENABLE_SET, OFF_FAULT_IRQ_ENABLE_CLEAR:
					rdata_next[NUM_EVENTS-1:0] = fault_irq_enable_reg;
				default: rdata_next = 32'h0000_0000;
			endcase
		end
		if (psel && !penable && !mapped)
			err_next = 1'b1;
		irq_next = |(events & fault_irq_enable_reg);
	end

	// Register all state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pub_reg <= '{enable: RST_PUB_EN, channel: RST_PUBLISH_CHANNEL_INDEX};
			fault_irq_enable_reg <= RST_FAULT_IRQ_ENABLE;
			rdata_reg <= 32'h0000_0000;
			err_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			pub_reg <= pub_next;
			fault_irq_enable_reg <= fault_irq_enable_next;
			rdata_reg <= rdata_next;
			err_reg <= err_next;
			irq_reg <= irq_next;
		end
	end

	assign prdata = rdata_reg;
	assign pslverr = err_reg && psel && penable;
	assign irq = irq_reg;
endmodule : access_fault_event_irq_enable

// ==== verilog/fault_event_flag.sv ====
// One sticky event flag: hardware sets, software writes the event register
`timescale 1ns/1ps
module fault_event_flag (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, active low
	input wire logic detect, // Violation detect pulse
	input wire logic sw_write, // Software writes this event register
	input wire logic sw_value, // Bit 0 of the written data
	output logic flag // Event register state
);
	import fault_irq_pkg::*;
	logic flag_reg;
	logic flag_next;

	// Detection wins over a software write in the same cycle
	always_comb begin
		flag_next = flag_reg;
		if (sw_write)
			flag_next = sw_value;
		if (detect)
			flag_next = 1'b1;
	end

	// Flag register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			flag_reg <= 1'b0;
		else
			flag_reg <= flag_next;
	end

	assign flag = flag_reg;
endmodule : fault_event_flag

// ==== verilog/fault_irq_pkg.sv ====
// Package with register map, field layout and types for the fault block
package fault_irq_pkg;
	localparam int ADDR_W = 12;
	localparam int NUM_EVENTS = 3;
	localparam int PUBLISH_CHANNEL_INDEX_W = 16;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_EVT_RAM = 12'h100;
	localparam logic [ADDR_W-1:0] OFF_EVT_FLASH = 12'h104;
	localparam logic [ADDR_W-1:0] OFF_EVT_PERIPH = 12'h108;
	localparam logic [ADDR_W-1:0] OFF_PUBLISH = 12'h188;
	localparam logic [ADDR_W-1:0] OFF_FAULT_IRQ_ENABLE = 12'h300;
	localparam logic [ADDR_W-1:0] OFF_FAULT_IRQ_ENABLE_SET = 12'h304;
	localparam logic [ADDR_W-1:0] OFF_FAULT_IRQ_ENABLE_CLEAR = 12'h308;
	// Field positions
	localparam int POS_PUBLISH_CHANNEL_INDEX = 0;
	localparam int POS_PUB_EN = 31;
	localparam int POS_RAM = 0;
	localparam int POS_FLASH = 1;
	localparam int POS_PERIPH = 2;
	// Reset values
	localparam logic [PUBLISH_CHANNEL_INDEX_W-1:0] RST_PUBLISH_CHANNEL_INDEX = 16'h0000;
	localparam logic RST_PUB_EN = 1'b0;
	localparam logic [NUM_EVENTS-1:0] RST_FAULT_IRQ_ENABLE = 3'h0;
	localparam logic [NUM_EVENTS-1:0] RST_EVENTS = 3'h0;

	// Publish configuration fields
	typedef struct packed {
		logic enable;
		logic [PUBLISH_CHANNEL_INDEX_W-1:0] channel;
	} publish_cfg_t;

	// One decoded APB write
	typedef struct packed {
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [31:0] data;
	} reg_write_t;
endpackage : fault_irq_pkg

// ==== verilog/fault_publish.sv ====
// Publish path: pulses the selected channel when an event fires
`timescale 1ns/1ps
module fault_publish #(
	parameter int NUM_CHANNELS = 16
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, active low
	input fault_irq_pkg::publish_cfg_t cfg, // Publish configuration
	input wire logic event_pulse, // Event occurred this cycle
	output logic [NUM_CHANNELS-1:0] channel_pulse // One-hot channel pulses
);
	import fault_irq_pkg::*;
	logic [NUM_CHANNELS-1:0] pulse_reg;
	logic [NUM_CHANNELS-1:0] pulse_next;

	initial begin
		if (NUM_CHANNELS < 1 || NUM_CHANNELS > (1 << PUBLISH_CHANNEL_INDEX_W))
			$error("NUM_CHANNELS out of range");
	end

	// Decode the channel; out-of-range index or disabled publishes nothing
	always_comb begin
		pulse_next = '0;
		if (event_pulse && cfg.enable) begin
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				if (cfg.channel == PUBLISH_CHANNEL_INDEX_W'(i))
					pulse_next[i] = 1'b1;
			end
		end
	end

	// Registered channel output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pulse_reg <= '0;
		else
			pulse_reg <= pulse_next;
	end

	assign channel_pulse = pulse_reg;
endmodule : fault_publish
